/* scb_feature_ctrl.sv */
// System feature control register and its instruction gating
// Functional notes
// - Extension bit selects 64-bit entries, 52-bit addresses
// - Extension bit permits 4K or 2M pages
// - Long mode needs extension bit set
// - Bit 6 gates uncorrectable machine-check exception
// - Enabled errors always logged
// - Banks hold report enable and status
// - Correctable errors logged, never raise exception
// - Bit 7 enables global page marking
// - Base write flushes non-global cache entries
// - Bit 8 opens counter read to all
// - Bit 9 clear: legacy SIMD invalid opcode
// - Bit 10 clear: SIMD fault becomes invalid
// - Bit 16 enables segment base instructions
// - Bit 18 enables extended state instructions
// - Bit 20 blocks supervisor user-page execution
// - Reserved control numbers raise invalid opcode
// - Prefix extension bit in 64-bit mode widens control register field
// - Unimplemented extended register raises invalid opcode
// - Register eight is task priority
// - Enable bits writable, reserved bits zero
`timescale 1ns/1ps
`default_nettype none
module scb_feature_ctrl
  import scb_pkg::*;
#(
  parameter int unsigned PRIO_W = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire scb_pkg::scb_cr_req_t cr_req_i,
  input wire logic base_write_i,
  input wire logic long_mode_req_i,
  input wire scb_pkg::scb_instr_t instr_i,
  input wire logic pde_page_size_i,
  input wire logic entry_global_i,
  input wire logic mc_err_i,
  input wire logic mc_err_uncorr_i,
  input wire logic mc_bank_en_i,
  output logic [63:0] cr_rdata_o,
  output logic cr_ack_o,
  output logic invalid_opcode_o,
  output logic simd_fp_exc_o,
  output logic supervisor_fault_o,
  output logic long_mode_o,
  output logic flush_nonglobal_o,
  output logic flush_all_o,
  output logic [PRIO_W-1:0] task_priority_o,
  output logic [63:0] feature_o,
  output scb_pkg::scb_xlate_t xlate_o,
  output logic mc_exc_o,
  output logic mc_logged_o,
  output logic mc_logged_uncorr_o
);
  import scb_pkg::*;

  // Tests one enable bit of the stored feature word
  function automatic logic feat_on(input logic [63:0] feat, input int unsigned idx);
    return feat[idx];
  endfunction : feat_on

  // Register group
  logic [63:0] feat_reg, feat_next;
  logic [PRIO_W-1:0] prio_reg, prio_next;
  logic [63:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;

  // Instruction outcome group
  logic inv_reg, inv_next;
  logic sfe_reg, sfe_next;
  logic supf_reg, supf_next;
  logic lm_reg, lm_next;

  // Translation-cache flush group
  scb_state_t state_reg, state_next;
  logic fng_reg, fng_next;
  logic fall_reg, fall_next;

  // Translation format group
  scb_xlate_t xl_w;
  scb_xlate_t xl_reg, xl_next;

  // Decoded enables and refusal causes
  logic phys_ext_on, mc_exc_on, global_on, cnt_read_on;
  logic simd_on, simd_handler_on, seg_base_on, ext_state_on, sup_exec_on;
  logic [3:0] crn;
  logic crn_ok;
  logic inv_cr, inv_ins;
  logic cnt_refused, simd_refused, fp_refused, seg_refused, ext_refused;

  // Instructions see the registered value, so a write affects only later ones
  always_comb begin
    phys_ext_on = feat_on(feat_reg, BIT_PHYS_EXT);
    mc_exc_on = feat_on(feat_reg, BIT_MC_EXC);
    global_on = feat_on(feat_reg, BIT_GLOBAL_PG);
    cnt_read_on = feat_on(feat_reg, BIT_CNT_READ);
    simd_on = feat_on(feat_reg, BIT_FXSR);
    simd_handler_on = feat_on(feat_reg, BIT_XMMX);
    seg_base_on = feat_on(feat_reg, BIT_SEGB);
    ext_state_on = feat_on(feat_reg, BIT_XSV);
    sup_exec_on = feat_on(feat_reg, BIT_SUP_EXEC);
  end

  scb_xlate_sel u_xl (
    .phys_ext_i(phys_ext_on),
    .global_en_i(global_on),
    .pde_page_size_i(pde_page_size_i),
    .entry_global_i(entry_global_i),
    .xl_o(xl_w)
  );

  scb_mc_gate u_mc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .mc_enable_i(mc_exc_on),
    .err_i(mc_err_i),
    .err_uncorr_i(mc_err_uncorr_i),
    .bank_report_en_i(mc_bank_en_i),
    .exc_o(mc_exc_o),
    .logged_o(mc_logged_o),
    .logged_uncorr_o(mc_logged_uncorr_o)
  );

  always_comb begin
    // Upper number bit exists only with the prefix in 64-bit mode
    crn = {cr_req_i.long64 & cr_req_i.rex_ext, cr_req_i.crn_low};
    crn_ok = scb_crn_valid(crn);
    inv_cr = cr_req_i.valid & ~crn_ok;
  end

  always_comb begin
    cnt_refused = instr_i.perf_read & ~cnt_read_on & (instr_i.priv_level != PL_KERNEL);
    simd_refused = instr_i.legacy_simd & ~simd_on;
    fp_refused = instr_i.simd_fp_unmasked & ~simd_handler_on;
    seg_refused = instr_i.seg_base & ~seg_base_on;
    ext_refused = (instr_i.ext_ctrl_get_set | instr_i.ext_save) & ~ext_state_on;
    inv_ins = cnt_refused | simd_refused | fp_refused | seg_refused | ext_refused;
  end

  always_comb begin
    feat_next = feat_reg;
    prio_next = prio_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    if (cr_req_i.valid && crn_ok) begin
      ack_next = 1'b1;
      if (cr_req_i.write) begin
        case (crn)
          // Reserved bits forced low so they always read as zero
          CRN_FEAT: feat_next = cr_req_i.wdata & FEAT_WMASK;
          CRN_TASK_PRIO: prio_next = cr_req_i.wdata[PRIO_W-1:0];
          default: feat_next = feat_reg;
        endcase
      end else begin
        case (crn)
          CRN_FEAT: rdata_next = feat_reg;
          CRN_TASK_PRIO: rdata_next = 64'(prio_reg);
          default: rdata_next = 64'h0000_0000_0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      feat_reg <= FEAT_RESET;
      prio_reg <= PRIO_W'(PRIO_RESET);
      rdata_reg <= 64'h0000_0000_0000_0000;
      ack_reg <= 1'b0;
    end else begin
      feat_reg <= feat_next;
      prio_reg <= prio_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  always_comb begin
    inv_next = inv_cr | inv_ins;
    // Without handler support the fault becomes an invalid opcode instead
    sfe_next = instr_i.simd_fp_unmasked & simd_handler_on;
    supf_next = instr_i.supervisor & instr_i.fetch_user_page & sup_exec_on;
    // Long mode needs the wide entries, so it is refused without them
    lm_next = long_mode_req_i & phys_ext_on;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      inv_reg <= 1'b0;
      sfe_reg <= 1'b0;
      supf_reg <= 1'b0;
      lm_reg <= 1'b0;
    end else begin
      inv_reg <= inv_next;
      sfe_reg <= sfe_next;
      supf_reg <= supf_next;
      lm_reg <= lm_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    fng_next = 1'b0;
    fall_next = 1'b0;
    case (state_reg)
      SCB_IDLE: begin
        if (base_write_i) begin
          state_next = SCB_FLUSH;
        end
      end
      SCB_FLUSH: begin
        // Global entries survive only while global pages are enabled
        fng_next = global_on;
        fall_next = ~global_on;
        state_next = base_write_i ? SCB_FLUSH : SCB_IDLE;
      end
      default: state_next = SCB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= SCB_IDLE;
      fng_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fng_reg <= fng_next;
      fall_reg <= fall_next;
    end
  end

  // Registered so that the output comes straight from flip-flops
  always_comb begin
    xl_next = xl_w;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xl_reg <= '0;
    end else begin
      xl_reg <= xl_next;
    end
  end

  assign cr_rdata_o = rdata_reg;
  assign cr_ack_o = ack_reg;
  assign invalid_opcode_o = inv_reg;
  assign simd_fp_exc_o = sfe_reg;
  assign supervisor_fault_o = supf_reg;
  assign long_mode_o = lm_reg;
  assign flush_nonglobal_o = fng_reg;
  assign flush_all_o = fall_reg;
  assign task_priority_o = prio_reg;
  assign feature_o = feat_reg;
  assign xlate_o = xl_reg;
endmodule : scb_feature_ctrl
`default_nettype wire

/* scb_feature_ctrl_checker.sv */
// Assertion checker for the system feature control block
`timescale 1ns/1ps
`default_nettype none
module scb_feature_ctrl_checker
  import scb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire scb_pkg::scb_cr_req_t cr_req_i,
  input wire logic base_write_i,
  input wire scb_pkg::scb_instr_t instr_i,
  input wire logic mc_err_i,
  input wire logic mc_err_uncorr_i,
  input wire logic cr_ack_o,
  input wire logic invalid_opcode_o,
  input wire logic flush_nonglobal_o,
  input wire logic flush_all_o,
  input wire logic [63:0] feature_o,
  input wire logic mc_exc_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_feat_write_mask: assert property (cr_req_i.valid && cr_req_i.write && !(cr_req_i.rex_ext && cr_req_i.long64)
    && cr_req_i.crn_low == 3'h4 |=> feature_o == $past(cr_req_i.wdata & FEAT_WMASK))
    else $error("feature write not masked");
  a_crn_reserved: assert property (cr_req_i.valid && cr_req_i.crn_low inside {3'h1, 3'h5, 3'h6, 3'h7}
    |=> invalid_opcode_o && !cr_ack_o) else $error("reserved register accepted");
  a_crn_ext_unimpl: assert property (cr_req_i.valid && cr_req_i.rex_ext && cr_req_i.long64
    && cr_req_i.crn_low != 3'h0 |=> invalid_opcode_o && !cr_ack_o) else $error("extended register accepted");
  // Same-cycle register writes excluded: flush may see the new value
  a_flush_keep_global: assert property (base_write_i && feature_o[BIT_GLOBAL_PG] && !cr_req_i.valid
    |-> ##2 flush_nonglobal_o && !flush_all_o) else $error("global entries not kept");
  a_flush_all_noglobal: assert property (base_write_i && !feature_o[BIT_GLOBAL_PG] && !cr_req_i.valid
    |-> ##2 flush_all_o && !flush_nonglobal_o) else $error("full flush missing");
  a_mc_exc_raise: assert property (mc_err_i && mc_err_uncorr_i && feature_o[BIT_MC_EXC] |=> mc_exc_o)
    else $error("machine check exception missing");
  a_mc_exc_cause: assert property (mc_exc_o |-> $past(mc_err_i && mc_err_uncorr_i && feature_o[BIT_MC_EXC]))
    else $error("machine check exception without cause");
  a_perf_priv_gate: assert property (instr_i.perf_read && instr_i.priv_level != PL_KERNEL
    && !feature_o[BIT_CNT_READ] |=> invalid_opcode_o) else $error("counter read not refused");
  a_legacy_simd_gate: assert property (instr_i.legacy_simd && !feature_o[BIT_FXSR] |=> invalid_opcode_o)
    else $error("legacy SIMD not refused");
endmodule : scb_feature_ctrl_checker
bind scb_feature_ctrl scb_feature_ctrl_checker u_scb_feature_ctrl_checker (.clk_i, .reset_i, .cr_req_i,
  .base_write_i, .instr_i, .mc_err_i, .mc_err_uncorr_i, .cr_ack_o, .invalid_opcode_o, .flush_nonglobal_o,
  .flush_all_o, .feature_o, .mc_exc_o);
`default_nettype wire

/* scb_mc_gate.sv */
// Machine-check exception gating and logging
`timescale 1ns/1ps
`default_nettype none
module scb_mc_gate (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic mc_enable_i,
  input wire logic err_i,
  input wire logic err_uncorr_i,
  input wire logic bank_report_en_i,
  output logic exc_o,
  output logic logged_o,
  output logic logged_uncorr_o
);
  logic logged_reg, logged_next, unc_reg, unc_next, exc_reg, exc_next;
  always_comb begin
    logged_next = logged_reg;
    unc_next = unc_reg;
    exc_next = 1'b0;
    if (err_i && bank_report_en_i) begin
      logged_next = 1'b1;
      unc_next = unc_reg | err_uncorr_i;
    end
    if (err_i && err_uncorr_i && mc_enable_i) begin
      exc_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      logged_reg <= 1'b0;
      unc_reg <= 1'b0;
      exc_reg <= 1'b0;
    end else begin
      logged_reg <= logged_next;
      unc_reg <= unc_next;
      exc_reg <= exc_next;
    end
  end
  assign exc_o = exc_reg;
  assign logged_o = logged_reg;
  assign logged_uncorr_o = unc_reg;
endmodule : scb_mc_gate
`default_nettype wire

/* scb_pkg.sv */
// Package for the system feature control register block
package scb_pkg;
  localparam int unsigned CTRL_W = 64;
  localparam int unsigned PHYS_ADDR_W = 52;
  localparam int unsigned BIT_PHYS_EXT = 5;
  localparam int unsigned BIT_MC_EXC = 6;
  localparam int unsigned BIT_GLOBAL_PG = 7;
  localparam int unsigned BIT_CNT_READ = 8;
  localparam int unsigned BIT_FXSR = 9;
  localparam int unsigned BIT_XMMX = 10;
  localparam int unsigned BIT_SEGB = 16;
  localparam int unsigned BIT_XSV = 18;
  localparam int unsigned BIT_SUP_EXEC = 20;
  localparam logic [63:0] FEAT_WMASK = 64'h0000_0000_0015_07E0;
  localparam logic [63:0] FEAT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [3:0] CRN_TASK_PRIO = 4'h8;
  localparam logic [3:0] CRN_FEAT = 4'h4;
  localparam logic [3:0] CRN_BASE_CTRL = 4'h0;
  localparam logic [3:0] CRN_FAULT_ADDR = 4'h2;
  localparam logic [3:0] CRN_PAGE_BASE = 4'h3;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [1:0] PL_KERNEL = 2'h0;
  localparam int unsigned PAGE_SMALL_SHIFT = 12;
  localparam int unsigned PAGE_LARGE_SHIFT = 21;
  localparam int unsigned ENTRY_W_LEGACY = 32;
  localparam int unsigned ENTRY_W_EXT = 64;

  typedef enum logic [1:0] {SCB_IDLE, SCB_FLUSH} scb_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic rex_ext;
    logic long64;
    logic [2:0] crn_low;
    logic [63:0] wdata;
  } scb_cr_req_t;

  typedef struct packed {
    logic perf_read;
    logic legacy_simd;
    logic simd_fp_unmasked;
    logic seg_base;
    logic ext_ctrl_get_set;
    logic ext_save;
    logic fetch_user_page;
    logic supervisor;
    logic [1:0] priv_level;
  } scb_instr_t;

  typedef struct packed {
    logic ext_entries;
    logic large_page;
    logic global_page;
    logic [6:0] entry_width;
  } scb_xlate_t;

  function automatic logic scb_crn_valid(input logic [3:0] crn);
    return (crn == CRN_BASE_CTRL) || (crn == CRN_FAULT_ADDR) || (crn == CRN_PAGE_BASE) || (crn == CRN_FEAT)
      || (crn == CRN_TASK_PRIO);
  endfunction : scb_crn_valid
endpackage : scb_pkg

/* scb_xlate_sel.sv */
// Translation format selection from feature bits
`timescale 1ns/1ps
`default_nettype none
module scb_xlate_sel
  import scb_pkg::*;
(
  input wire logic phys_ext_i,
  input wire logic global_en_i,
  input wire logic pde_page_size_i,
  input wire logic entry_global_i,
  output scb_pkg::scb_xlate_t xl_o
);
  import scb_pkg::*;
  always_comb begin
    xl_o.ext_entries = phys_ext_i;
    xl_o.entry_width = phys_ext_i ? 7'(ENTRY_W_EXT) : 7'(ENTRY_W_LEGACY);
    xl_o.large_page = phys_ext_i & pde_page_size_i;
    xl_o.global_page = global_en_i & entry_global_i;
  end
endmodule : scb_xlate_sel
`default_nettype wire

/* test_scb_feature_ctrl.sv */
// Self-checking bench for the system feature control block
`timescale 1ns/1ps
`default_nettype none
module test_scb_feature_ctrl;
  import scb_pkg::*;
  logic clk_i = 0, reset_i = 1, bw = 0, lm = 0, pgs = 0, gl = 0, me = 0, mu = 0, mb = 0;
  logic ack, inv, sfe, sf, lmo, fng, fal, mx, ml, mlu;
  logic [63:0] rd, fo, q;
  logic [3:0] tp;
  scb_xlate_t xl;
  scb_cr_req_t req = '0;
  scb_instr_t ins = '0;
  int fails = 0, checked = 0;
  scb_instr_t it [8] = '{10'h203, 10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010, 10'h00C};
  logic [2:0] off_e [8] = '{3'h4, 3'h0, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0};
  logic [2:0] on_e [8] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h1};
  scb_feature_ctrl u_scb_feature_ctrl (.clk_i(clk_i), .reset_i(reset_i), .cr_req_i(req), .base_write_i(bw),
    .long_mode_req_i(lm), .instr_i(ins), .pde_page_size_i(pgs), .entry_global_i(gl), .mc_err_i(me),
    .mc_err_uncorr_i(mu), .mc_bank_en_i(mb), .cr_rdata_o(rd), .cr_ack_o(ack), .invalid_opcode_o(inv),
    .simd_fp_exc_o(sfe), .supervisor_fault_o(sf), .long_mode_o(lmo), .flush_nonglobal_o(fng),
    .flush_all_o(fal), .task_priority_o(tp), .feature_o(fo), .xlate_o(xl), .mc_exc_o(mx),
    .mc_logged_o(ml), .mc_logged_uncorr_o(mlu));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic cr(input logic w, input logic [3:0] n, input logic [63:0] d, input logic ok);
    @(posedge clk_i) req <= {1'b1, w, n[3], n[3], n[2:0], d};
    @(posedge clk_i) req <= '0;
    #1 q = rd;
    chk("ack", ok, ack);
    chk("invalid", !ok, inv);
  endtask : cr
  task automatic run(input scb_instr_t i, input logic [2:0] e);
    @(posedge clk_i) ins <= i;
    @(posedge clk_i) ins <= '0;
    #1 chk("instr", e, {inv, sfe, sf});
  endtask : run
  task automatic pulse_mc(input logic u, input logic [2:0] e);
    @(posedge clk_i) {me, mu} <= {1'b1, u};
    @(posedge clk_i) {me, mu} <= 2'h0;
    #1 chk("mcheck", e, {mx, ml, mlu});
  endtask : pulse_mc
  task automatic flush(input logic [1:0] e);
    @(posedge clk_i) bw <= 1'b1;
    @(posedge clk_i) bw <= 1'b0;
    @(posedge clk_i) #1 chk("flush", e, {fng, fal});
  endtask : flush
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    mb <= 1'b1;
    #1 chk("feature", 64'h0, fo);
    // First pass with every enable clear, second with all set
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) run(it[k], p ? on_e[k] : off_e[k]);
      cr(1'b1, 4'h4, 64'h0000_0000_0000_0200, 1'b1);
      cr(1'b1, 4'h4, '1, 1'b1);
      chk("feature", FEAT_WMASK, fo);
    end
    $display("test gating done");
    for (int n = 0; n < 16; n++) cr(1'b1, 4'(n), '1, n inside {0, 2, 3, 4, 8});
    cr(1'b0, 4'h4, '0, 1'b1);
    chk("read", FEAT_WMASK, q);
    chk("priority", 4'hF, tp);
    cr(1'b0, 4'h8, '0, 1'b1);
    chk("priority read", 64'h0000_0000_0000_000F, q);
    cr(1'b0, 4'h2, '0, 1'b1);
    chk("plain read", 64'h0000_0000_0000_0000, q);
    pulse_mc(1'b0, 3'h2);
    pulse_mc(1'b1, 3'h7);
    @(posedge clk_i) {lm, pgs, gl} <= 3'h7;
    repeat (2) @(posedge clk_i);
    #1 chk("xlate", {1'b1, 3'h7, 7'h40}, {lmo, xl});
    flush(2'h2);
    cr(1'b1, 4'h4, '0, 1'b1);
    flush(2'h1);
    repeat (2) @(posedge clk_i);
    #1 chk("xlate", {1'b0, 3'h0, 7'h20}, {lmo, xl});
    // Write and instruction in one cycle: the instruction still sees the old value
    @(posedge clk_i) begin
      req <= {1'b1, 1'b1, 2'h0, 3'h4, 64'h0000_0000_0000_0200};
      ins <= 10'h100;
    end
    @(posedge clk_i) req <= '0;
    #1 chk("same cycle", 1'b1, inv);
    @(posedge clk_i) ins <= '0;
    #1 chk("next cycle", 1'b0, inv);
    pulse_mc(1'b1, 3'h3);
    $display("test features done");
    tally_and_finish;
  end
  initial begin
    #20us;
    fails++;
    tally_and_finish;
  end
endmodule : test_scb_feature_ctrl
`default_nettype wire
